// ==== verilog/dbgu_uart.sv ====
`timescale 1ns/100ps
// Overview of operation
// - Idle serial line stays high between frames.
// - Frame: low start, eight data bits LSB first, high stop.
// - Status bit 4 set when received stop bit is low.
// - Status bit 3 copies old receive-full flag on each transfer, cleared if a data read falls in that cycle.
// - Status bit 2 set on unread data, cleared by data read.
// - Status bit 1 shows transmit holding register occupied.
// - Status bit 0 shows transmit shifter sending a frame.
// - Low data read returns byte in 7:0, zero above.
// - Receive interrupt on each move into receive holding register.
// - Low data write takes 7:0; idle transmitter starts at once.
// - Busy transmitter: byte held, full flag set, sent afterwards.
// - High data port same as low, using bits 15:8.
// - Divider: first in 15:8, second in 7:0, resets zero.
// - Bit rate is clock over (first+1) times second divider.
// - Holding empties and transmit interrupt fires as frame starts.
// - Receiver treats a high-to-low line edge as start bit.
// - Data bits sampled mid-bit, shifted in LSB first.
// - After a frame the receiver returns to idle.
// - Receiver samples on the first divider output tick.
module dbgu_uart (
  input wire logic sys_clk_in,          // Master clock
  input wire logic sys_rst_in,          // Sync reset, high
  input wire logic [15:0] io_addr_in,   // I/O address
  input wire logic io_wr_in,            // Write strobe
  input wire logic io_rd_in,            // Read strobe
  input wire logic [15:0] io_wdata_in,  // Write data
  output logic [15:0] io_rdata_out,     // Read data, next cycle
  input wire logic rxd_in,              // Serial receive line
  output logic txd_out,                 // Serial transmit line
  output logic transmit_interrupt_out,  // Transmit request pulse
  output logic receive_interrupt_out    // Receive request pulse
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] baud_divider_ff;
  logic [7:0] prescale_cnt_ff;
  logic [7:0] tx_hold_ff;
  logic [7:0] rx_hold_ff;
  logic [15:0] rdata_ff;
  logic tx_holding_full_flag_ff;
  logic rx_holding_full_flag_ff;
  logic rx_overrun_flag_ff;
  logic rx_framing_error_flag_ff;
  logic tx_irq_ff;
  logic rx_irq_ff;
  logic [7:0] prescale_divider;
  logic [7:0] bit_period_divider;
  logic sample_tick;
  logic sel_status;
  logic sel_lo;
  logic sel_hi;
  logic sel_div;
  logic data_wr;
  logic data_rd;
  logic [7:0] wr_byte;
  logic tx_busy;
  logic tx_load;
  logic [7:0] tx_byte;
  logic direct_load;
  logic hold_load;
  logic rx_done;
  logic [7:0] rx_byte;
  logic rx_stop;
  logic [4:0] line_status_port;
  logic [15:0] nxt_rdata;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Register selects
  assign sel_status = io_addr_in == dbgu_pkg::ADDR_STATUS;
  assign sel_lo = io_addr_in == dbgu_pkg::ADDR_DATA_LO;
  assign sel_hi = io_addr_in == dbgu_pkg::ADDR_DATA_HI;
  assign sel_div = io_addr_in == dbgu_pkg::ADDR_DIV;

  // Data port strobes, either byte lane
  // Both lanes share one transmitter and one receiver
  assign data_wr = io_wr_in & (sel_lo | sel_hi);
  assign data_rd = io_rd_in & (sel_lo | sel_hi);

  // Write byte from the addressed lane
  // high lane on the high port, low lane otherwise
  assign wr_byte = sel_hi ?
    io_wdata_in[dbgu_pkg::BYTE_HI_MSB:dbgu_pkg::BYTE_HI_LSB] :
    io_wdata_in[dbgu_pkg::BYTE_LO_MSB:dbgu_pkg::BYTE_LO_LSB];

  // ----------------------------------------------------------------
  // Divider register
  // ----------------------------------------------------------------

  assign prescale_divider =
    baud_divider_ff[dbgu_pkg::DIV1_MSB:dbgu_pkg::DIV1_LSB];
  assign bit_period_divider =
    baud_divider_ff[dbgu_pkg::DIV2_MSB:dbgu_pkg::DIV2_LSB];

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      baud_divider_ff <= dbgu_pkg::DIV_RESET;
    end else if (io_wr_in && sel_div) begin
      baud_divider_ff <= io_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // First divider
  // ----------------------------------------------------------------

  // One tick every first divider plus one clocks
  // prescale sample tick
  assign sample_tick = prescale_cnt_ff == prescale_divider;

  // A count above a lowered divider restarts at once
  // divide by first plus one
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      prescale_cnt_ff <= 8'h00;
    end else if (sample_tick || prescale_cnt_ff > prescale_divider) begin
      prescale_cnt_ff <= 8'h00;
    end else begin
      prescale_cnt_ff <= prescale_cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------

  // A held byte always goes first, so bytes keep their order
  // idle write goes straight to shifter
  assign direct_load = data_wr & ~tx_busy & ~tx_holding_full_flag_ff;
  assign hold_load = tx_holding_full_flag_ff & ~tx_busy;
  assign tx_load = direct_load | hold_load;
  assign tx_byte = hold_load ? tx_hold_ff : wr_byte;

  // A write while full replaces the held byte; set wins over empty
  // holding register and full flag
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tx_hold_ff <= dbgu_pkg::BYTE_RESET;
      tx_holding_full_flag_ff <= 1'b0;
    end else if (data_wr && !direct_load) begin
      tx_hold_ff <= wr_byte;
      tx_holding_full_flag_ff <= 1'b1;
    end else if (hold_load) begin
      tx_holding_full_flag_ff <= 1'b0;
    end
  end

  dbgu_tx u_tx (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in (sample_tick),
    .div2_in (bit_period_divider),
    .load_in (tx_load),
    .byte_in (tx_byte),
    .busy_out (tx_busy),
    .txd_out (txd_out)
  );

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------

  // Receiver shares the sample tick with the transmitter
  // start detection
  dbgu_rx u_rx (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .tick_in (sample_tick),
    .div2_in (bit_period_divider),
    .rxd_in (rxd_in),
    .done_out (rx_done),
    .byte_out (rx_byte),
    .stop_out (rx_stop)
  );

  // Receive holding register, overwritten by each new byte
  // transfer on frame completion
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rx_hold_ff <= dbgu_pkg::BYTE_RESET;
    end else if (rx_done) begin
      rx_hold_ff <= rx_byte;
    end
  end

  // Arrival and read in one cycle leave the flag set
  // full flag, set beats clear
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rx_holding_full_flag_ff <= 1'b0;
    end else if (rx_done) begin
      rx_holding_full_flag_ff <= 1'b1;
    end else if (data_rd) begin
      rx_holding_full_flag_ff <= 1'b0;
    end
  end

  // A read in the transfer cycle counts as taken
  // overrun copies old full
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rx_overrun_flag_ff <= 1'b0;
    end else if (rx_done) begin
      rx_overrun_flag_ff <= rx_holding_full_flag_ff & ~data_rd;
    end
  end

  // Error kept until the next byte, reads do not clear it
  // framing error on low stop
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rx_framing_error_flag_ff <= 1'b0;
    end else if (rx_done) begin
      rx_framing_error_flag_ff <= ~rx_stop;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tx_irq_ff <= 1'b0;
    end else begin
      tx_irq_ff <= tx_load;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rx_irq_ff <= 1'b0;
    end else begin
      rx_irq_ff <= rx_done;
    end
  end

  assign transmit_interrupt_out = tx_irq_ff;
  assign receive_interrupt_out = rx_irq_ff;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Unused upper status bits read as zero
  // holding occupied
  always_comb begin
    line_status_port = dbgu_pkg::STATUS_RESET;
    line_status_port[dbgu_pkg::ST_TX_ACTIVE] = tx_busy;
    line_status_port[dbgu_pkg::ST_TX_FULL] = tx_holding_full_flag_ff;
    line_status_port[dbgu_pkg::ST_RX_FULL] = rx_holding_full_flag_ff;
    line_status_port[dbgu_pkg::ST_RX_ORUN] = rx_overrun_flag_ff;
    line_status_port[dbgu_pkg::ST_FRAME_ERR] = rx_framing_error_flag_ff;
  end

  // Unmapped addresses read as zero
  // low byte, zero above
  always_comb begin
    nxt_rdata = 16'h0000;
    if (sel_status) begin
      nxt_rdata = {11'h000, line_status_port};
    end else if (sel_lo) begin
      nxt_rdata = {8'h00, rx_hold_ff};
    end else if (sel_hi) begin
      nxt_rdata = {rx_hold_ff, 8'h00};
    end else if (sel_div) begin
      nxt_rdata = baud_divider_ff;
    end
  end

  // Read data register, held until next read
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rdata_ff <= 16'h0000;
    end else if (io_rd_in) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign io_rdata_out = rdata_ff;

endmodule : dbgu_uart

// ==== verilog/dbgu_pkg.sv ====
package dbgu_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_STATUS = 16'hc028;
  localparam logic [15:0] ADDR_DATA_LO = 16'hc029;
  localparam logic [15:0] ADDR_DATA_HI = 16'hc02a;
  localparam logic [15:0] ADDR_DIV = 16'hc02b;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_TX_ACTIVE = 0;
  localparam int ST_TX_FULL = 1;
  localparam int ST_RX_FULL = 2;
  localparam int ST_RX_ORUN = 3;
  localparam int ST_FRAME_ERR = 4;
  localparam int ST_WIDTH = 5;
  localparam int DIV1_MSB = 15;
  localparam int DIV1_LSB = 8;
  localparam int DIV2_MSB = 7;
  localparam int DIV2_LSB = 0;
  localparam int BYTE_LO_MSB = 7;
  localparam int BYTE_LO_LSB = 0;
  localparam int BYTE_HI_MSB = 15;
  localparam int BYTE_HI_LSB = 8;

  // ----------------------------------------------------------------
  // Reset values and frame shape
  // ----------------------------------------------------------------
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] FRAME_BITS = 4'ha;
  localparam logic [3:0] DATA_BITS = 4'h8;

  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } dbgu_rx_state_e;

  // True on the tick that ends a count of target ticks
  function automatic logic dbgu_cnt_done(input logic [7:0] cnt,
                                         input logic [7:0] target);
    dbgu_cnt_done = ({1'b0, cnt} + 9'h001) >= {1'b0, target};
  endfunction : dbgu_cnt_done

endpackage : dbgu_pkg

// ==== verilog/dbgu_tx.sv ====
`timescale 1ns/100ps
module dbgu_tx (
  input wire logic sys_clk_in,       // Master clock
  input wire logic sys_rst_in,       // Sync reset, high
  input wire logic tick_in,          // Prescaled sample tick
  input wire logic [7:0] div2_in,    // Ticks per bit
  input wire logic load_in,          // Start a frame
  input wire logic [7:0] byte_in,    // Byte to send
  output logic busy_out,             // Shifter active
  output logic txd_out               // Serial line
);

  logic [9:0] shift_ff;
  logic [3:0] bit_ff;
  logic [7:0] tcnt_ff;
  logic busy_ff;
  logic txd_ff;
  logic bit_end;
  logic last_bit;

  // Bit period end and last bit detection
  assign bit_end = busy_ff & tick_in &
                   dbgu_pkg::dbgu_cnt_done(tcnt_ff, div2_in);
  assign last_bit = bit_ff == (dbgu_pkg::FRAME_BITS - 4'h1);

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      shift_ff <= 10'h3ff;
      bit_ff <= 4'h0;
      tcnt_ff <= 8'h00;
      busy_ff <= 1'b0;
    end else if (load_in && !busy_ff) begin
      shift_ff <= {1'b1, byte_in, 1'b0};
      bit_ff <= 4'h0;
      tcnt_ff <= 8'h00;
      busy_ff <= 1'b1;
    end else if (bit_end) begin
      shift_ff <= {1'b1, shift_ff[9:1]};
      bit_ff <= bit_ff + 4'h1;
      tcnt_ff <= 8'h00;
      busy_ff <= !last_bit;
    end else if (busy_ff && tick_in) begin
      tcnt_ff <= tcnt_ff + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      txd_ff <= 1'b1;
    end else if (load_in && !busy_ff) begin
      txd_ff <= 1'b0;
    end else if (bit_end) begin
      txd_ff <= last_bit ? 1'b1 : shift_ff[1];
    end
  end

  assign busy_out = busy_ff;
  assign txd_out = txd_ff;

endmodule : dbgu_tx

// ==== verilog/dbgu_rx.sv ====
`timescale 1ns/100ps
module dbgu_rx (
  input wire logic sys_clk_in,       // Master clock
  input wire logic sys_rst_in,       // Sync reset, high
  input wire logic tick_in,          // Prescaled sample tick
  input wire logic [7:0] div2_in,    // Ticks per bit
  input wire logic rxd_in,           // Serial line in
  output logic done_out,             // Frame received pulse
  output logic [7:0] byte_out,       // Received byte
  output logic stop_out              // Sampled stop bit
);

  dbgu_pkg::dbgu_rx_state_e state_ff;
  dbgu_pkg::dbgu_rx_state_e nxt_state;
  logic [7:0] tcnt_ff;
  logic [7:0] shift_ff;
  logic [3:0] bit_ff;
  logic rxd_prev_ff;
  logic done_ff;
  logic stop_ff;
  logic fall;
  logic half_end;
  logic full_end;

  // Edge and sample point detection
  assign fall = rxd_prev_ff & ~rxd_in;
  assign half_end = tick_in &
                    dbgu_pkg::dbgu_cnt_done(tcnt_ff, {1'b0, div2_in[7:1]});
  assign full_end = tick_in & dbgu_pkg::dbgu_cnt_done(tcnt_ff, div2_in);

  // State sequence
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dbgu_pkg::RX_IDLE: begin
        if (fall) begin
          nxt_state = dbgu_pkg::RX_START;
        end
      end
      dbgu_pkg::RX_START: begin
        if (half_end) begin
          nxt_state = rxd_in ? dbgu_pkg::RX_IDLE : dbgu_pkg::RX_DATA;
        end
      end
      dbgu_pkg::RX_DATA: begin
        if (full_end && bit_ff == dbgu_pkg::DATA_BITS - 4'h1) begin
          nxt_state = dbgu_pkg::RX_STOP;
        end
      end
      dbgu_pkg::RX_STOP: begin
        if (full_end) begin
          nxt_state = dbgu_pkg::RX_IDLE;
        end
      end
      default: nxt_state = dbgu_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_ff <= dbgu_pkg::RX_IDLE;
      tcnt_ff <= 8'h00;
      shift_ff <= dbgu_pkg::BYTE_RESET;
      bit_ff <= 4'h0;
      rxd_prev_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      rxd_prev_ff <= rxd_in;
      if (nxt_state != state_ff) begin
        tcnt_ff <= 8'h00;
      end else if (state_ff != dbgu_pkg::RX_IDLE && tick_in) begin
        tcnt_ff <= full_end ? 8'h00 : tcnt_ff + 8'h01;
      end
      if (state_ff == dbgu_pkg::RX_START) begin
        bit_ff <= 4'h0;
      end else if (state_ff == dbgu_pkg::RX_DATA && full_end) begin
        shift_ff <= {rxd_in, shift_ff[7:1]};
        bit_ff <= bit_ff + 4'h1;
      end
    end
  end

  // Stop sample and completion pulse
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      done_ff <= 1'b0;
      stop_ff <= 1'b1;
    end else begin
      done_ff <= (state_ff == dbgu_pkg::RX_STOP) && full_end;
      if ((state_ff == dbgu_pkg::RX_STOP) && full_end) begin
        stop_ff <= rxd_in;
      end
    end
  end

  assign done_out = done_ff;
  assign byte_out = shift_ff;
  assign stop_out = stop_ff;

endmodule : dbgu_rx

// ==== verification/dbgu_uart_monitor.sv ====
`timescale 1ns/100ps
module dbgu_uart_monitor (
  input wire logic sys_clk_in, // Master clock
  input wire logic sys_rst_in, // Sync reset, high
  input wire logic [15:0] io_addr_in, // I/O address
  input wire logic io_wr_in, // Write strobe
  input wire logic io_rd_in, // Read strobe
  input wire logic [15:0] io_wdata_in, // Write data
  input wire logic [15:0] io_rdata_out, // Read data
  input wire logic rxd_in, // Receive line
  input wire logic txd_out, // Transmit line
  input wire logic transmit_interrupt_out, // Transmit pulse
  input wire logic receive_interrupt_out // Receive pulse
);
  logic [15:0] div_ff;
  logic [19:0] cnt_ff;
  logic [19:0] nxt_cnt;
  logic [19:0] d1;
  logic [19:0] bit_len;
  logic [19:0] st_beg;
  logic [19:0] fr_len;
  logic [19:0] age;
  logic wr_data;

  // ----------------------------------------------------------------
  // Frame timing reference
  // ----------------------------------------------------------------
  // Bit length from the divider shadow, age since last frame start
  assign d1 = {12'h000, div_ff[15:8]};
  assign bit_len = (d1 + 20'h0_0001) * {12'h000, div_ff[7:0]};
  assign st_beg = bit_len * 20'h0_0009;
  assign fr_len = bit_len * 20'h0_000a;
  assign age = transmit_interrupt_out ? 20'h0_0000 : cnt_ff;
  // Saturates well below the top, so age plus d1 cannot wrap
  assign nxt_cnt = (age >= 20'hf_0000) ? age : age + 20'h0_0001;
  assign wr_data = io_wr_in && (io_addr_in == dbgu_pkg::ADDR_DATA_LO ||
                                io_addr_in == dbgu_pkg::ADDR_DATA_HI);

  // Divider shadow and saturating age counter
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      div_ff <= 16'h0000;
      cnt_ff <= 20'hf_0000;
    end else begin
      if (io_wr_in && io_addr_in == dbgu_pkg::ADDR_DIV)
        div_ff <= io_wdata_in;
      cnt_ff <= nxt_cnt;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_start_bit_low: assert property (
    age + d1 < bit_len |-> !txd_out) else $error("start bit not low");
  a_stop_bit_high: assert property (
    age >= st_beg && age + d1 + 20'h0_0001 < fr_len |-> txd_out)
    else $error("stop bit not high");
  a_line_idle_high: assert property (
    age >= fr_len + 20'h0_0004 |-> txd_out) else $error("idle line low");
  a_wr_idle_start: assert property (
    wr_data && age >= fr_len + 20'h0_0004 |=>
    transmit_interrupt_out ##1 !transmit_interrupt_out)
    else $error("idle write did not start a frame");
  a_tx_irq_spacing: assert property (
    transmit_interrupt_out |-> cnt_ff >= st_beg)
    else $error("frame start inside a frame");
  a_rx_irq_single: assert property (
    receive_interrupt_out |=> !receive_interrupt_out [*8])
    else $error("receive pulse too long");
  a_lo_read_zero: assert property (
    io_rd_in && io_addr_in == dbgu_pkg::ADDR_DATA_LO |=>
    io_rdata_out[15:8] == 8'h00) else $error("low port upper not zero");
  a_hi_read_zero: assert property (
    io_rd_in && io_addr_in == dbgu_pkg::ADDR_DATA_HI |=>
    io_rdata_out[7:0] == 8'h00) else $error("high port lower not zero");
  a_div_readback: assert property (
    io_rd_in && io_addr_in == dbgu_pkg::ADDR_DIV |=>
    io_rdata_out == $past(div_ff)) else $error("divider readback wrong");
  a_rdata_holds: assert property (
    !io_rd_in |=> $stable(io_rdata_out)) else $error("read data moved");

  c_tx_start: cover property (transmit_interrupt_out);
  c_rx_byte: cover property (receive_interrupt_out);
  c_overrun: cover property (io_rd_in &&
    io_addr_in == dbgu_pkg::ADDR_STATUS ##1 io_rdata_out[3]);
endmodule : dbgu_uart_monitor

bind dbgu_uart dbgu_uart_monitor u_mon (
  .sys_clk_in(sys_clk_in),
  .sys_rst_in(sys_rst_in),
  .io_addr_in(io_addr_in),
  .io_wr_in(io_wr_in),
  .io_rd_in(io_rd_in),
  .io_wdata_in(io_wdata_in),
  .io_rdata_out(io_rdata_out),
  .rxd_in(rxd_in),
  .txd_out(txd_out),
  .transmit_interrupt_out(transmit_interrupt_out),
  .receive_interrupt_out(receive_interrupt_out)
);

// ==== verification/dbgu_term_model.sv ====
`timescale 1ns/100ps
module dbgu_term_model #(
  parameter int BIT_CLKS = 12
) (
  input wire logic sys_clk_in, // Master clock
  input wire logic txd_in, // Line from the block
  input wire logic send_go_in, // Start a frame
  input wire logic [7:0] send_byte_in, // Byte to send
  input wire logic send_stop_in, // Stop bit level
  output logic rxd_out, // Line to the block
  output logic [7:0] got_byte_out, // Last byte heard
  output logic got_stop_out, // Its stop bit
  output logic [7:0] got_cnt_out // Frames heard
);
  logic [9:0] frame;
  logic [7:0] shift;
  int i;
  int j;

  // ----------------------------------------------------------------
  // Serial terminal
  // ----------------------------------------------------------------
  // Line idle and counters at start
  initial begin
    rxd_out = 1'b1;
    got_byte_out = 8'h00;
    got_stop_out = 1'b0;
    got_cnt_out = 8'h00;
  end

  always @(posedge send_go_in) begin
    frame = {send_stop_in, send_byte_in, 1'b0};
    for (i = 0; i < 10; i++) begin
      rxd_out = frame[i];
      repeat (BIT_CLKS) @(negedge sys_clk_in);
    end
    rxd_out = 1'b1;
  end

  always @(negedge txd_in) begin
    repeat (BIT_CLKS / 2) @(negedge sys_clk_in);
    for (j = 0; j < 8; j++) begin
      repeat (BIT_CLKS) @(negedge sys_clk_in);
      shift = {txd_in, shift[7:1]};
    end
    repeat (BIT_CLKS) @(negedge sys_clk_in);
    got_byte_out = shift;
    got_stop_out = txd_in;
    got_cnt_out = got_cnt_out + 8'h01;
  end
endmodule : dbgu_term_model

// ==== verification/debug_serial_uart_tb_top.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module debug_serial_uart_tb_top;
  localparam logic [7:0] D1 = 8'h01;
  localparam logic [7:0] D2 = 8'h06;
  localparam int BIT = (1 + 1) * 6;
  logic sys_clk_in;
  logic sys_rst_in;
  logic [15:0] io_addr_in;
  logic io_wr_in;
  logic io_rd_in;
  logic [15:0] io_wdata_in;
  logic [15:0] io_rdata_out;
  logic rxd_in;
  logic txd_out;
  logic tx_irq;
  logic rx_irq;
  logic go;
  logic [7:0] go_byte;
  logic go_stop;
  logic [7:0] got_byte;
  logic got_stop;
  logic [7:0] got_cnt;
  logic [7:0] b0;
  logic [7:0] b1;
  int errors;
  int cmp_count;
  int tx_irqs;
  int rx_irqs;
  int i;
  int k;

  dbgu_uart DUT (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
    .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
    .rxd_in(rxd_in), .txd_out(txd_out), .transmit_interrupt_out(tx_irq),
    .receive_interrupt_out(rx_irq));
  dbgu_term_model #(.BIT_CLKS(BIT)) u_term (.sys_clk_in(sys_clk_in),
    .txd_in(txd_out), .send_go_in(go), .send_byte_in(go_byte),
    .send_stop_in(go_stop), .rxd_out(rxd_in), .got_byte_out(got_byte),
    .got_stop_out(got_stop), .got_cnt_out(got_cnt));

  // ----------------------------------------------------------------
  // Clock, pulse counters, helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  // Count interrupt pulses
  always @(posedge sys_clk_in) begin
    if (tx_irq === 1'b1) tx_irqs++;
    if (rx_irq === 1'b1) rx_irqs++;
  end

  // Status word from flags {frame, overrun, rxfull, txfull, txactive}
  function automatic logic [15:0] exp_st(input logic [4:0] f);
    exp_st = 16'h0000;
    exp_st[dbgu_pkg::ST_FRAME_ERR] = f[4];
    exp_st[dbgu_pkg::ST_RX_ORUN] = f[3];
    exp_st[dbgu_pkg::ST_RX_FULL] = f[2];
    exp_st[dbgu_pkg::ST_TX_FULL] = f[1];
    exp_st[dbgu_pkg::ST_TX_ACTIVE] = f[0];
  endfunction : exp_st

  function automatic logic [15:0] lane(input logic [7:0] b, input logic hi);
    lane = hi ? {b, 8'h00} : {8'h00, b};
  endfunction : lane

  task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk_in);
    io_addr_in = a;
    io_wdata_in = d;
    io_wr_in = 1'b1;
    @(negedge sys_clk_in);
    io_wr_in = 1'b0;
  endtask : bus_wr

  task automatic chk_rd(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    @(negedge sys_clk_in);
    io_addr_in = a;
    io_rd_in = 1'b1;
    @(negedge sys_clk_in);
    io_rd_in = 1'b0;
    d = io_rdata_out;
    `CHK(d, e)
  endtask : chk_rd

  // Terminal sends one whole frame
  task automatic send(input logic [7:0] b, input logic s);
    @(negedge sys_clk_in);
    go_byte = b;
    go_stop = s;
    go = 1'b1;
    @(negedge sys_clk_in);
    go = 1'b0;
    repeat (10 * BIT) @(negedge sys_clk_in);
  endtask : send

  task automatic wait_ev(input int rxn, input int gotn);
    for (k = 0; k < 4000 && (rx_irqs < rxn || got_cnt < gotn); k++)
      @(negedge sys_clk_in);
    // Running out of time counts as a mismatch
    if (k >= 4000) errors++;
  endtask : wait_ev

  task automatic summarize;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // Watchdog
  initial begin
    #2000000;
    errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    k = $urandom(32'h0000_1327);
    io_addr_in = 16'h0000;
    io_wr_in = 1'b0;
    io_rd_in = 1'b0;
    io_wdata_in = 16'h0000;
    go = 1'b0;
    go_byte = 8'h00;
    go_stop = 1'b1;
    sys_rst_in = 1'b1;
    repeat (8) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    for (i = 0; i < 5; i++)
      chk_rd(dbgu_pkg::ADDR_STATUS + 16'(i), 16'h0000);
    bus_wr(dbgu_pkg::ADDR_DIV, {D1, D2});
    bus_wr(dbgu_pkg::ADDR_STATUS, 16'hffff);
    chk_rd(dbgu_pkg::ADDR_DIV, {D1, D2});
    chk_rd(dbgu_pkg::ADDR_STATUS, 16'h0000);
    // Back-to-back bytes: second waits in holding
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    bus_wr(dbgu_pkg::ADDR_DATA_LO, {8'($urandom), b0});
    bus_wr(dbgu_pkg::ADDR_DATA_HI, {b1, 8'($urandom)});
    chk_rd(dbgu_pkg::ADDR_STATUS, exp_st(5'h03));
    `CHK(tx_irqs, 1)
    wait_ev(0, 1);
    `CHK(got_byte, b0)
    `CHK(got_stop, 1'b1)
    repeat (2 * BIT) @(negedge sys_clk_in);
    chk_rd(dbgu_pkg::ADDR_STATUS, exp_st(5'h01));
    `CHK(tx_irqs, 2)
    wait_ev(0, 2);
    `CHK(got_byte, b1)
    repeat (BIT) @(negedge sys_clk_in);
    chk_rd(dbgu_pkg::ADDR_STATUS, 16'h0000);
    // Receive, bad stop, then overrun
    send(b0, 1'b1);
    wait_ev(1, 2);
    `CHK(rx_irqs, 1)
    chk_rd(dbgu_pkg::ADDR_STATUS, exp_st(5'h04));
    chk_rd(dbgu_pkg::ADDR_DATA_LO, lane(b0, 1'b0));
    chk_rd(dbgu_pkg::ADDR_STATUS, 16'h0000);
    send(b1, 1'b0);
    wait_ev(2, 2);
    chk_rd(dbgu_pkg::ADDR_STATUS, exp_st(5'h14));
    send(~b0, 1'b1);
    wait_ev(3, 2);
    chk_rd(dbgu_pkg::ADDR_STATUS, exp_st(5'h0c));
    chk_rd(dbgu_pkg::ADDR_DATA_HI, lane(~b0, 1'b1));
    chk_rd(dbgu_pkg::ADDR_STATUS, exp_st(5'h08));
    // Random traffic in both directions at once
    for (i = 0; i < 6; i++) begin
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      fork
        send(b0, 1'b1);
        bus_wr(dbgu_pkg::ADDR_DATA_LO, {8'($urandom), b1});
      join
      wait_ev(4 + i, 3 + i);
      `CHK(rx_irqs, 4 + i)
      `CHK(got_byte, b1)
      chk_rd(dbgu_pkg::ADDR_DATA_LO, lane(b0, 1'b0));
    end
    repeat (12 * BIT) @(negedge sys_clk_in);
    `CHK(tx_irqs, 8)
    summarize();
  end
endmodule : debug_serial_uart_tb_top
